// *** smsp_regs.svh ***
// Purpose: register indices, field positions, reset values and divider counts of the serial port
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef SMSP_REGS_SVH
`define SMSP_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define SMSP_IDX_AUX 8'ha2
`define SMSP_IDX_CTRL 8'hf3
`define SMSP_IDX_STAT 8'hf4
`define SMSP_IDX_DATA 8'hf5
`define SMSP_IDX_MASK 8'hf6

// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define SMSP_AUX_RST 8'h00
`define SMSP_CTRL_RST 8'h00
`define SMSP_STAT_RST 8'h00
`define SMSP_DATA_RST 8'h00
`define SMSP_MASK_RST 8'h00
`define SMSP_AUX_WMASK 8'hc9
`define SMSP_EVT_MASK 8'hf0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SMSP_AUX_PINSEL 7
`define SMSP_CTRL_SELECT_OUTPUT_ENABLE 7
`define SMSP_CTRL_EN 6
`define SMSP_CTRL_LSBF 5
`define SMSP_CTRL_MASTER_SELECT 4
`define SMSP_CTRL_CPOL 3
`define SMSP_CTRL_CPHA 2
`define SMSP_CTRL_SPR_HI 1
`define SMSP_CTRL_SPR_LO 0
`define SMSP_STAT_DONE 7
`define SMSP_STAT_WCOL 6
`define SMSP_STAT_OVF 5
`define SMSP_STAT_MODE_FAULT_FLAG 4
`define SMSP_STAT_FAULT_DETECT_DISABLE 3

// ----------------------------------------------------------------
// master half-period reloads (half period minus one, system clocks)
// ----------------------------------------------------------------
`define SMSP_HALF_M1_DIV16 7'd7
`define SMSP_HALF_M1_DIV32 7'd15
`define SMSP_HALF_M1_DIV64 7'd31
`define SMSP_HALF_M1_DIV128 7'd63
`define SMSP_LAST_BIT 3'd7

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define SMSP_RESP_OKAY 2'b00
`define SMSP_RESP_SLVERR 2'b10

`endif

// *** smsp_pkg.sv ***
// Purpose: types shared by the serial port
// Assumes: nothing
// Notes: pin groups travel as one packed struct
package smsp_pkg;

  // ----------------------------------------------------------------
  // pin group and state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ss;
    logic sclk;
    logic miso;
    logic mosi;
  } smsp_pins_t;

  typedef enum logic [0:0] {
    SMSP_ST_IDLE = 1'b0,
    SMSP_ST_SHIFT = 1'b1
  } smsp_state_t;

endpackage

// *** smsp_port.sv ***
// Purpose: serial peripheral port, master or slave, with an AXI4-Lite register slave
// Assumes: pins resolved outside from out/oe_n; link signals sampled on aclk
// Notes: Function
// Function
// - master or slave; master clock at most sys/16
// - one shifter plus a separate read buffer
// - no shifter load during a transfer; a selected slave still accepts a load until its first bit is sampled
// - finished byte moves into read buffer
// - mosi master to slave, miso back
// - shift clock driven as master, input as slave
// - eight clocks per byte, shift in step
// - select low for access; high deactivates slave
// - master: select pin general or fault input
// - transfer swaps the two shift registers
// - msb first, lsb first when bit set
// - pin group select bit routes four signals
// - auto select output only when enabled
// - enable bit 6 switches whole port
// - bit 4 chooses slave or master
// - select pin as multi-master fault input
// - flag mode fault at once on low select
// - done flag set; data writes blocked meanwhile
`include "smsp_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module smsp_port
  import smsp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire smsp_pins_t grp0_in,
  output smsp_pins_t grp0_out,
  output smsp_pins_t grp0_oe_n,
  input wire smsp_pins_t grp1_in,
  output smsp_pins_t grp1_out,
  output smsp_pins_t grp1_oe_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] aux_r;
  logic [7:0] ctrl_r;
  logic [7:0] stat_r;
  logic [7:0] mask_r;
  logic [7:0] rxbuf_r;
  logic [7:0] sh_r;
  logic outbit_r;
  logic last_r;
  logic sclk_r;
  logic [2:0] bitcnt_r;
  logic [6:0] divcnt_r;
  smsp_state_t state_r;
  smsp_pins_t s1_r, s2_r, s3_r, filt_r, filt_d_r;
  logic aw_hold_r, w_hold_r, awready_r, wready_r, bvalid_r;
  logic arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [7:0] awidx_r, rdata_r;
  logic [7:0] wdata_r;
  logic wstrb_r;
  smsp_pins_t g0_out_r, g0_oe_n_r, g1_out_r, g1_oe_n_r;
  logic irq_r;

  // ----------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------
  wire en = ctrl_r[`SMSP_CTRL_EN];
  wire mst = ctrl_r[`SMSP_CTRL_MASTER_SELECT];
  wire lsbf = ctrl_r[`SMSP_CTRL_LSBF];
  wire cpol = ctrl_r[`SMSP_CTRL_CPOL];
  wire cpha = ctrl_r[`SMSP_CTRL_CPHA];
  wire select_output_enable = ctrl_r[`SMSP_CTRL_SELECT_OUTPUT_ENABLE];
  wire fault_detect_disable = stat_r[`SMSP_STAT_FAULT_DETECT_DISABLE];
  wire pinsel = aux_r[`SMSP_AUX_PINSEL];
  wire [1:0] spr = ctrl_r[`SMSP_CTRL_SPR_HI:`SMSP_CTRL_SPR_LO];
  wire [6:0] half_m1 = (spr == 2'h0) ? `SMSP_HALF_M1_DIV16 :
                       (spr == 2'h1) ? `SMSP_HALF_M1_DIV32 :
                       (spr == 2'h2) ? `SMSP_HALF_M1_DIV64 : `SMSP_HALF_M1_DIV128;
  wire ss_auto = en & mst & fault_detect_disable & select_output_enable;
  wire fault_chk = en & mst & ~fault_detect_disable;
  wire fault_evt = fault_chk & ~filt_r.ss;
  wire slv_sel = en & ~mst & ~filt_r.ss;
  wire shifting = (state_r == SMSP_ST_SHIFT);

  // ----------------------------------------------------------------
  // input synchronisers on the selected pin group
  // ----------------------------------------------------------------
  wire smsp_pins_t pin_in = pinsel ? grp1_in : grp0_in;
  wire smsp_pins_t filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r | s3_r));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      filt_r <= '1;
      filt_d_r <= '1;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
      filt_d_r <= filt_r;
    end
  end

  // ----------------------------------------------------------------
  // edge detection, master and slave
  // ----------------------------------------------------------------
  wire tick = shifting & mst & (divcnt_r == 7'h00);
  wire m_lead = tick & (sclk_r == cpol);
  wire m_trail = tick & (sclk_r != cpol);
  wire s_rise = filt_r.sclk & ~filt_d_r.sclk;
  wire s_fall = ~filt_r.sclk & filt_d_r.sclk;
  wire s_lead = slv_sel & shifting & (cpol ? s_fall : s_rise);
  wire s_trail = slv_sel & shifting & (cpol ? s_rise : s_fall);
  wire lead = mst ? m_lead : s_lead;
  wire trail = mst ? m_trail : s_trail;
  wire sample_e = cpha ? trail : lead;
  wire out_e = cpha ? lead : trail;
  wire in_bit = mst ? filt_r.miso : filt_r.mosi;
  wire front = lsbf ? sh_r[0] : sh_r[7];
  wire [7:0] sh_shift = lsbf ? {in_bit, sh_r[7:1]} : {sh_r[6:0], in_bit};
  wire last_sample = sample_e & (bitcnt_r == `SMSP_LAST_BIT);
  wire m_stop = m_trail & (last_r | last_sample);

  // ----------------------------------------------------------------
  // bus write decode
  // ----------------------------------------------------------------
  wire do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
  wire wr_ok = do_wr & wstrb_r;
  wire wr_aux = wr_ok & (awidx_r == `SMSP_IDX_AUX);
  wire wr_ctrl = wr_ok & (awidx_r == `SMSP_IDX_CTRL);
  wire wr_stat = wr_ok & (awidx_r == `SMSP_IDX_STAT);
  wire wr_data = wr_ok & (awidx_r == `SMSP_IDX_DATA);
  wire wr_mask = wr_ok & (awidx_r == `SMSP_IDX_MASK);
  wire wr_map = (awidx_r == `SMSP_IDX_AUX) | (awidx_r == `SMSP_IDX_CTRL) | (awidx_r == `SMSP_IDX_STAT) |
                (awidx_r == `SMSP_IDX_DATA) | (awidx_r == `SMSP_IDX_MASK);
  wire busy = mst ? shifting : (slv_sel & (bitcnt_r != 3'h0));
  wire wcol_evt = wr_data & busy;
  wire load = wr_data & ~busy & ~stat_r[`SMSP_STAT_DONE] & en;
  wire start = load & mst;
  wire ovf_evt = last_sample & stat_r[`SMSP_STAT_DONE];
  wire [7:0] evt_set = {last_sample, wcol_evt, ovf_evt, fault_evt, 4'h0};
  wire [7:0] evt_clr = wr_stat ? (wdata_r & `SMSP_EVT_MASK) : 8'h00;

  // ----------------------------------------------------------------
  // shifter and transfer sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= SMSP_ST_IDLE;
      sh_r <= `SMSP_DATA_RST;
      rxbuf_r <= `SMSP_DATA_RST;
      outbit_r <= 1'b0;
      last_r <= 1'b0;
      bitcnt_r <= 3'h0;
      divcnt_r <= 7'h00;
      sclk_r <= 1'b0;
    end else if (!en || (!mst && !slv_sel)) begin
      state_r <= SMSP_ST_IDLE;
      bitcnt_r <= 3'h0;
      last_r <= 1'b0;
      sclk_r <= cpol;
      sh_r <= load ? wdata_r : sh_r;
      outbit_r <= load ? (lsbf ? wdata_r[0] : wdata_r[7]) : front;
    end else if (start) begin
      state_r <= SMSP_ST_SHIFT;
      sh_r <= wdata_r;
      outbit_r <= lsbf ? wdata_r[0] : wdata_r[7];
      divcnt_r <= half_m1;
      bitcnt_r <= 3'h0;
      last_r <= 1'b0;
    end else begin
      if (!mst && !shifting) begin
        state_r <= SMSP_ST_SHIFT;
      end
      if (load) begin
        sh_r <= wdata_r;
      end else if (sample_e) begin
        sh_r <= sh_shift;
      end
      if (sample_e) begin
        bitcnt_r <= bitcnt_r + 3'h1;
      end
      if (out_e) begin
        outbit_r <= front;
      end else if (!shifting) begin
        outbit_r <= front;
      end
      if (last_sample) begin
        rxbuf_r <= sh_shift;
      end
      if (tick) begin
        divcnt_r <= half_m1;
        sclk_r <= ~sclk_r;
      end else if (shifting && mst) begin
        divcnt_r <= divcnt_r - 7'h01;
      end
      if (m_stop) begin
        state_r <= SMSP_ST_IDLE;
        last_r <= 1'b0;
      end else if (last_sample) begin
        last_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers, events and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_r <= `SMSP_AUX_RST;
      ctrl_r <= `SMSP_CTRL_RST;
      stat_r <= `SMSP_STAT_RST;
      mask_r <= `SMSP_MASK_RST;
      irq_r <= 1'b0;
    end else begin
      if (wr_aux) begin
        aux_r <= wdata_r & `SMSP_AUX_WMASK;
      end
      if (wr_ctrl) begin
        ctrl_r <= wdata_r;
      end
      if (wr_mask) begin
        mask_r <= wdata_r & `SMSP_EVT_MASK;
      end
      // set wins over a write-one clear
      stat_r[7:4] <= ((stat_r[7:4] & ~evt_clr[7:4]) | evt_set[7:4]);
      if (wr_stat) begin
        stat_r[`SMSP_STAT_FAULT_DETECT_DISABLE] <= wdata_r[`SMSP_STAT_FAULT_DETECT_DISABLE];
      end
      irq_r <= |(stat_r & mask_r & `SMSP_EVT_MASK);
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  wire drv_m = en & mst;
  wire drv_miso = slv_sel;
  wire smsp_pins_t pin_out = '{ss: ~shifting, sclk: sclk_r, miso: outbit_r, mosi: outbit_r};
  wire smsp_pins_t pin_oe_n = '{ss: ~ss_auto, sclk: ~drv_m, miso: ~drv_miso, mosi: ~drv_m};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      g0_out_r <= '0;
      g1_out_r <= '0;
      g0_oe_n_r <= '1;
      g1_oe_n_r <= '1;
    end else begin
      g0_out_r <= pinsel ? '0 : pin_out;
      g0_oe_n_r <= pinsel ? '1 : pin_oe_n;
      g1_out_r <= pinsel ? pin_out : '0;
      g1_oe_n_r <= pinsel ? pin_oe_n : '1;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  wire aw_fire = s_axi_awvalid & awready_r;
  wire w_fire = s_axi_wvalid & wready_r;
  wire ar_fire = s_axi_arvalid & arready_r;
  wire aw_hold_n = (aw_hold_r | aw_fire) & ~do_wr;
  wire w_hold_n = (w_hold_r | w_fire) & ~do_wr;
  wire bvalid_n = (bvalid_r & ~s_axi_bready) | do_wr;
  wire rvalid_n = (rvalid_r & ~s_axi_rready) | ar_fire;
  wire [7:0] aridx = s_axi_araddr[9:2];
  wire rd_map = (aridx == `SMSP_IDX_AUX) | (aridx == `SMSP_IDX_CTRL) | (aridx == `SMSP_IDX_STAT) |
                (aridx == `SMSP_IDX_DATA) | (aridx == `SMSP_IDX_MASK);
  wire [7:0] rd_val = (aridx == `SMSP_IDX_AUX) ? aux_r :
                      (aridx == `SMSP_IDX_CTRL) ? ctrl_r :
                      (aridx == `SMSP_IDX_STAT) ? stat_r :
                      (aridx == `SMSP_IDX_DATA) ? rxbuf_r :
                      (aridx == `SMSP_IDX_MASK) ? mask_r : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `SMSP_RESP_OKAY;
      awidx_r <= 8'h00;
      wdata_r <= 8'h00;
      wstrb_r <= 1'b0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= `SMSP_RESP_OKAY;
      rdata_r <= 8'h00;
    end else begin
      aw_hold_r <= aw_hold_n;
      w_hold_r <= w_hold_n;
      bvalid_r <= bvalid_n;
      rvalid_r <= rvalid_n;
      awready_r <= ~aw_hold_n & ~bvalid_n;
      wready_r <= ~w_hold_n & ~bvalid_n;
      arready_r <= ~rvalid_n;
      if (aw_fire) begin
        awidx_r <= s_axi_awaddr[9:2];
      end
      if (w_fire) begin
        wdata_r <= s_axi_wdata[7:0];
        wstrb_r <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        bresp_r <= wr_map ? `SMSP_RESP_OKAY : `SMSP_RESP_SLVERR;
      end
      if (ar_fire) begin
        rdata_r <= rd_val;
        rresp_r <= rd_map ? `SMSP_RESP_OKAY : `SMSP_RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = {24'h000000, rdata_r};
  assign grp0_out = g0_out_r;
  assign grp0_oe_n = g0_oe_n_r;
  assign grp1_out = g1_out_r;
  assign grp1_oe_n = g1_oe_n_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  done_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    last_sample |=> stat_r[`SMSP_STAT_DONE]) else $error("done flag not set after byte");

  busy_write_ref_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_data && busy) |=> (stat_r[`SMSP_STAT_WCOL] && sh_r == ($past(sample_e) ? $past(sh_shift) : $past(sh_r))))
    else $error("write during transfer not refused");

  rx_buffer_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    last_sample |=> (rxbuf_r == $past(sh_shift))) else $error("read buffer not loaded");

  logic [11:0] wait_cyc_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || last_sample) begin
      wait_cyc_r <= 12'h000;
    end else if (start || wait_cyc_r != 12'h000) begin
      wait_cyc_r <= wait_cyc_r + 12'h001;
    end
  end
  eight_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wait_cyc_r <= 12'd2100) else $error("byte did not finish");

  master_clk_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (en && mst && !pinsel) [*2] |-> (!g0_oe_n_r.sclk && !g0_oe_n_r.mosi)) else $error("master clock not driven");

  auto_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ss_auto && shifting && !pinsel) |=> (!g0_out_r.ss || !shifting)) else $error("select not low in transfer");

  fault_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_evt |=> stat_r[`SMSP_STAT_MODE_FAULT_FLAG]) else $error("mode fault not flagged");

  slave_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (en && !mst && filt_r.ss) |=> (bitcnt_r == 3'h0 && !shifting)) else $error("deselected slave still active");

  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (irq_r == |($past(stat_r) & $past(mask_r) & `SMSP_EVT_MASK))) else $error("interrupt level wrong");

  disabled_port_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !en |=> (!shifting && g0_oe_n_r == '1 && g1_oe_n_r == '1)) else $error("disabled port active");

endmodule // smsp_port

`default_nettype wire

// *** smsp_peer.sv ***
// Purpose: mode 0 serial slave that faces one pin group of the port
// Assumes: select low frames one byte; shift clock idles low
// Notes: miso shows the inverse of its last bit while deselected
`timescale 1ns/10ps
`default_nettype none

module smsp_peer (
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] got
);
  logic [7:0] txl_r, sh_r, rx_r;
  logic [3:0] nf_r = 4'h0;
  logic last_r = 1'b0;
  // ----------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------
  // receive side collects on the rising clock, so the last falling
  // clock may meet the select edge without losing a bit
  assign miso = ss_n ? ~last_r : (nf_r == 4'h0 ? txl_r[7] : sh_r[7]);
  always @(negedge ss_n) txl_r <= tx;
  always @(posedge sclk) if (!ss_n) rx_r <= {rx_r[6:0], mosi};
  always @(negedge sclk or posedge ss_n) begin
    if (ss_n) nf_r <= 4'h0;
    else nf_r <= nf_r + 4'h1;
  end
  always @(negedge sclk) begin
    if (!ss_n) begin
      sh_r <= {(nf_r == 4'h0 ? txl_r[6:0] : sh_r[6:0]), 1'b0};
      last_r <= miso;
    end
  end
  always @(posedge ss_n) got <= rx_r;
endmodule // smsp_peer

`default_nettype wire

// *** tb.sv ***
// Purpose: self-checking bench of the serial port in master mode
// Assumes: a mode 0 peer slave sits on each pin group
// Notes: register reads are compared by a queue monitor
`include "smsp_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module tb
  import smsp_pkg::*;
;
  // ----------------------------------------------------------------
  // bench wiring
  // ----------------------------------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0, ss_ext = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, pmiso;
  smsp_pins_t gin [2], gout [2], goe [2];
  logic [7:0] ptx [2] = '{8'h00, 8'h00};
  logic [7:0] pgot [2];
  logic [7:0] ridx [6] = '{`SMSP_IDX_AUX, `SMSP_IDX_CTRL, `SMSP_IDX_STAT, `SMSP_IDX_DATA, `SMSP_IDX_MASK, 8'h10};
  logic [32:0] exp_q [$];
  int err_total = 0, cmp_count = 0, seed = 32'hb9a1;

  initial forever #2.5 aclk = ~aclk;

  for (genvar g = 0; g < 2; g++) begin : g_grp
    assign gin[g].ss = goe[g].ss ? ss_ext : gout[g].ss;
    assign gin[g].sclk = goe[g].sclk ? 1'b0 : gout[g].sclk;
    assign gin[g].mosi = goe[g].mosi ? 1'b0 : gout[g].mosi;
    assign gin[g].miso = goe[g].miso ? pmiso[g] : gout[g].miso;
    smsp_peer i_smsp_peer (.sclk(gin[g].sclk), .ss_n(gin[g].ss), .mosi(gin[g].mosi), .tx(ptx[g]),
      .miso(pmiso[g]), .got(pgot[g]));
  end

  smsp_port #(.ADDR_W(12)) i_smsp_port (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .grp0_in(gin[0]), .grp0_out(gout[0]), .grp0_oe_n(goe[0]), .grp1_in(gin[1]), .grp1_out(gout[1]),
    .grp1_oe_n(goe[1]), .irq(irq));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic give_up();
    err_total++;
    $display("ERROR bus answer expected within bound seen none");
    complete_run();
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
    int n;
    n = 0;
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n > 500) give_up();
    end while (!(bready && bvalid));
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, resp});
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic chk, input logic [7:0] e, output logic [7:0] q);
    int n;
    n = 0;
    exp_q.push_back({chk, 24'h000000, e});
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n > 500) give_up();
    end while (!(rready && rvalid));
    q = rdata[7:0];
    check("rresp", {30'h0, rresp}, {30'h0, ((idx == 8'h10) ? `SMSP_RESP_SLVERR : `SMSP_RESP_OKAY)});
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    logic [32:0] x;
    if (rvalid && rready && exp_q.size() > 0) begin
      x = exp_q.pop_front();
      if (x[32]) check("rdata", rdata, x[31:0]);
    end
  end

  task automatic wait_stat(input int b);
    logic [7:0] s;
    int n;
    n = 0;
    s = 8'h00;
    while (s[b] !== 1'b1) begin
      rd(`SMSP_IDX_STAT, 1'b0, 8'h00, s);
      n++;
      if (n > 600) give_up();
    end
  endtask

  function automatic logic [7:0] flip(input logic [7:0] v);
    for (int i = 0; i < 8; i++) flip[i] = v[7 - i];
  endfunction

  // done flag comes half a shift clock before select rises
  task automatic wait_idle(input logic sel);
    for (int i = 0; i < 200 && gin[sel].ss !== 1'b1; i++) @(posedge aclk);
    check("select idle", {31'h0, gin[sel].ss}, 32'h1);
  endtask

  task automatic xfer(input logic sel, input logic lsb, input logic [7:0] m, input logic [7:0] p);
    logic [7:0] q;
    ptx[sel] <= p;
    wr(`SMSP_IDX_DATA, m, `SMSP_RESP_OKAY);
    wait_stat(`SMSP_STAT_DONE);
    check("irq", {31'h0, irq}, 32'h1);
    check("idle group", {28'h0, goe[!sel]}, 32'hf);
    wait_idle(sel);
    check("peer byte", {24'h0, pgot[sel]}, {24'h0, lsb ? flip(m) : m});
    rd(`SMSP_IDX_DATA, 1'b1, lsb ? flip(p) : p, q);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] m, p, q;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (ridx[i]) rd(ridx[i], 1'b1, 8'h00, q);
    wr(8'h10, 8'hff, `SMSP_RESP_SLVERR);
    wr(`SMSP_IDX_STAT, 8'h08, `SMSP_RESP_OKAY);
    wr(`SMSP_IDX_MASK, 8'h80, `SMSP_RESP_OKAY);
    // the four passes also step the rate divider through all four settings
    for (int k = 0; k < 4; k++) begin
      wr(`SMSP_IDX_AUX, {k[1], 7'h00}, `SMSP_RESP_OKAY);
      wr(`SMSP_IDX_CTRL, {2'b11, k[0], 3'b100, k[1:0]}, `SMSP_RESP_OKAY);
      rd(`SMSP_IDX_CTRL, 1'b1, {2'b11, k[0], 3'b100, k[1:0]}, q);
      m = 8'($random(seed));
      p = 8'($random(seed));
      xfer(k[1], k[0], m, p);
      wr(`SMSP_IDX_STAT, 8'h88, `SMSP_RESP_OKAY);
      check("irq", {31'h0, irq}, 32'h0);
    end
    m = 8'($random(seed));
    p = 8'($random(seed));
    ptx[1] <= p;
    wr(`SMSP_IDX_DATA, m, `SMSP_RESP_OKAY);
    wr(`SMSP_IDX_DATA, ~m, `SMSP_RESP_OKAY);
    wait_stat(`SMSP_STAT_DONE);
    wr(`SMSP_IDX_DATA, 8'h3c, `SMSP_RESP_OKAY);
    rd(`SMSP_IDX_STAT, 1'b1, 8'hc8, q);
    wait_idle(1'b1);
    rd(`SMSP_IDX_DATA, 1'b1, flip(p), q);
    check("peer byte", {24'h0, pgot[1]}, {24'h0, flip(m)});
    wr(`SMSP_IDX_STAT, 8'hc8, `SMSP_RESP_OKAY);
    wr(`SMSP_IDX_MASK, 8'h10, `SMSP_RESP_OKAY);
    wr(`SMSP_IDX_STAT, 8'h00, `SMSP_RESP_OKAY);
    ss_ext <= 1'b0;
    wait_stat(4);
    check("irq", {31'h0, irq}, 32'h1);
    ss_ext <= 1'b1;
    rd(`SMSP_IDX_STAT, 1'b1, 8'h10, q);
    wr(`SMSP_IDX_STAT, 8'h10, `SMSP_RESP_OKAY);
    rd(`SMSP_IDX_STAT, 1'b1, 8'h00, q);
    complete_run();
  end
endmodule // tb

`default_nettype wire
